// File: design/rci_top.sv
// command and interrupt register group of the reader, reached over apb
`timescale 1ns/100ps
`default_nettype none
`include "rci_map.svh"

module rci_top #(
  parameter int           ADDR_W      = 12,
  parameter logic [3:0]   IDLE_CODE   = 4'h0,
  parameter logic [3:0]   REINIT_CODE = 4'hf,
  parameter logic [15:0]  KNOWN_CMDS  = 16'hffff
) (
  input  wire logic              CLK,
  input  wire logic              SYS_RST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic              TX_LAST_BIT_SENT,
  input  wire logic              RX_DONE_EV,
  input  wire logic              CMD_TERMINATED,
  input  wire logic              FIFO_HIGH_EV,
  input  wire logic              FIFO_LOW_EV,
  input  wire logic              FAULT_EV,
  input  wire logic              COUNTDOWN_EV,
  input  wire logic              EXT_SERIAL_INPUT,
  input  wire logic              CHECKSUM_EV,
  input  wire logic              WAKE_READY,
  output logic      [3:0]        CMD_CODE,
  output logic                   CMD_START,
  output logic                   RECEIVER_SHUTDOWN,
  output logic                   SOFT_SLEEP,
  output logic                   IRQ_O,
  output logic                   IRQ_OE,
  output logic                   INT_O
);

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------
  logic       pready_r;
  logic       pready_nxt;
  logic       wr_fire;
  logic [5:0] idx;
  logic       mapped;

  assign idx     = PADDR[7:2];
  // a write takes effect only at the edge where the master sees pready
  // an unmapped hit must not alias onto a register through the low index bits
  assign wr_fire = PSEL && PENABLE && PWRITE && pready_r && mapped;

  // upper address bits and byte offset must be zero for a hit
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (a[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if ((a >> 8) != '0) begin
      hit = 1'b0;
    end else if (a[7:2] <= `RCI_IDX_AUX_REQ) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  assign mapped = is_mapped(PADDR);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  rci_pkg::rci_cmd_t cmd_r,      cmd_nxt;
  logic              start_r,    start_nxt;
  logic              rx_off_r,   rx_off_nxt;
  rci_pkg::rci_pwr_e pwr_r,      pwr_nxt;
  logic              sleep_r;
  rci_pkg::rci_reg_t main_en_r,  main_en_nxt;
  rci_pkg::rci_reg_t aux_en_r,   aux_en_nxt;
  logic [6:0]        main_req_r, main_req_nxt;
  rci_pkg::rci_reg_t aux_req_r,  aux_req_nxt;
  logic              ext_prev_r;
  logic [31:0]       prdata_r,   prdata_nxt;
  logic              slverr_r,   slverr_nxt;
  logic              irq_stat;
  logic              pin_val;
  logic              irq_o_r,    irq_oe_r,  int_r;
  logic [7:0]        wd;
  logic [6:0]        main_ev;
  logic [7:0]        aux_ev;
  logic              idle_ev;

  assign wd = PWDATA[7:0];

  // ------------------------------------------------------------
  // command, receiver shutdown and power state
  // ------------------------------------------------------------
  // command writes and termination share one next-state process so
  // a host write and a termination in the same cycle resolve cleanly
  always_comb begin
    cmd_nxt    = cmd_r;
    start_nxt  = 1'b0;
    rx_off_nxt = rx_off_r;
    pwr_nxt    = pwr_r;
    idle_ev    = 1'b0;
    if (CMD_TERMINATED && cmd_r != IDLE_CODE) begin
      cmd_nxt = IDLE_CODE;
      idle_ev = 1'b1;
    end
    if (wr_fire && idx == `RCI_IDX_CMD) begin
      rx_off_nxt = wd[`RCI_CMD_RX_OFF];
      if (wd[3:0] == IDLE_CODE) begin
        cmd_nxt = IDLE_CODE;                                // host idle raises no flag
      end else if (KNOWN_CMDS[wd[3:0]]) begin
        cmd_nxt   = wd[3:0];
        start_nxt = 1'b1;
      end else begin
        cmd_nxt = IDLE_CODE;
        idle_ev = 1'b1;                                     // unknown code falls to idle
      end
      if (wd[`RCI_CMD_SLEEP]) begin
        // reinit in progress or being launched blocks the sleep request
        if (cmd_r != REINIT_CODE && wd[3:0] != REINIT_CODE) begin
          pwr_nxt = rci_pkg::RCI_ASLEEP;
        end
      end else if (pwr_r == rci_pkg::RCI_ASLEEP) begin
        pwr_nxt = rci_pkg::RCI_WAKING;
      end
    end
    case (pwr_r)
      rci_pkg::RCI_WAKING: begin
        if (WAKE_READY && pwr_nxt == rci_pkg::RCI_WAKING) begin
          pwr_nxt = rci_pkg::RCI_ACTIVE;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cmd_r    <= IDLE_CODE;
      start_r  <= 1'b0;
      rx_off_r <= 1'b1;                                     // 20h reset value
      pwr_r    <= rci_pkg::RCI_ACTIVE;
      sleep_r  <= 1'b0;
    end else begin
      cmd_r    <= cmd_nxt;
      start_r  <= start_nxt;
      rx_off_r <= rx_off_nxt;
      pwr_r    <= pwr_nxt;
      // sleep pin is its own flop so the output carries no decode glitch
      sleep_r  <= (pwr_nxt != rci_pkg::RCI_ACTIVE);
    end
  end

  // ------------------------------------------------------------
  // enables and request flags
  // ------------------------------------------------------------
  // events always win over a clear in the same cycle
  always_comb begin
    main_en_nxt  = main_en_r;
    aux_en_nxt   = aux_en_r;
    main_req_nxt = main_req_r;
    aux_req_nxt  = aux_req_r;
    main_ev      = {TX_LAST_BIT_SENT, RX_DONE_EV, idle_ev, FIFO_HIGH_EV,
                    FIFO_LOW_EV, FAULT_EV, COUNTDOWN_EV};
    aux_ev       = 8'h00;
    aux_ev[`RCI_AUX_EXT_ACT]  = EXT_SERIAL_INPUT ^ ext_prev_r;  // either edge
    aux_ev[`RCI_AUX_CHECKSUM] = CHECKSUM_EV;
    if (wr_fire) begin
      if (idx == `RCI_IDX_MAIN_EN) begin
        main_en_nxt = wd;
      end else if (idx == `RCI_IDX_AUX_EN) begin
        aux_en_nxt = wd & (`RCI_AUX_MASK | 8'h80);
      end else if (idx == `RCI_IDX_MAIN_REQ) begin
        if (wd[`RCI_REQ_SET_SEL]) begin
          main_req_nxt = main_req_r | wd[6:0];
        end else begin
          main_req_nxt = main_req_r & ~wd[6:0];
        end
      end else if (idx == `RCI_IDX_AUX_REQ) begin
        aux_req_nxt = aux_req_r & ~wd;                      // write one to clear
      end
    end
    main_req_nxt = main_req_nxt | main_ev;
    aux_req_nxt  = (aux_req_nxt | aux_ev) & `RCI_AUX_MASK;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      main_en_r  <= `RCI_RST_MAIN_EN;
      aux_en_r   <= `RCI_RST_AUX_EN;
      main_req_r <= 7'h14;                                  // 14h with selector bit dropped
      aux_req_r  <= `RCI_RST_AUX_REQ;
      ext_prev_r <= 1'b0;
    end else begin
      main_en_r  <= main_en_nxt;
      aux_en_r   <= aux_en_nxt;
      main_req_r <= main_req_nxt;
      aux_req_r  <= aux_req_nxt;
      ext_prev_r <= EXT_SERIAL_INPUT;
    end
  end

  // ------------------------------------------------------------
  // irq pin and interrupt output
  // ------------------------------------------------------------
  // pin state is computed from next values so the flops track the
  // registers with no extra cycle of lag
  assign irq_stat = |(main_req_nxt & main_en_nxt[6:0])
                  | |(aux_req_nxt & aux_en_nxt & `RCI_AUX_MASK);
  assign pin_val  = irq_stat ^ main_en_nxt[`RCI_EN_POL_INV];

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      irq_o_r  <= 1'b0;
      irq_oe_r <= 1'b0;                                     // released at reset
      int_r    <= 1'b0;
    end else begin
      int_r <= irq_stat;
      if (aux_en_nxt[`RCI_AUX_DRV_TYPE]) begin
        irq_o_r  <= pin_val;                                // push-pull
        irq_oe_r <= 1'b1;
      end else begin
        irq_o_r  <= 1'b0;                                   // open-drain pulls low only
        irq_oe_r <= ~pin_val;
      end
    end
  end

  // ------------------------------------------------------------
  // apb answer: one wait state, data and error registered
  // ------------------------------------------------------------
  always_comb begin
    pready_nxt = PSEL && PENABLE && !pready_r;
    prdata_nxt = prdata_r;
    slverr_nxt = 1'b0;
    if (pready_nxt) begin
      prdata_nxt = 32'h0000_0000;
      slverr_nxt = !mapped;
      if (!mapped) begin
        prdata_nxt = 32'h0000_0000;
      end else if (idx == `RCI_IDX_RSVD) begin
        prdata_nxt[7:0] = `RCI_RST_RSVD;
      end else if (idx == `RCI_IDX_CMD) begin
        prdata_nxt[7:0] = {2'b00, rx_off_r,
                           pwr_r != rci_pkg::RCI_ACTIVE, cmd_r};
      end else if (idx == `RCI_IDX_MAIN_EN) begin
        prdata_nxt[7:0] = main_en_r;
      end else if (idx == `RCI_IDX_AUX_EN) begin
        prdata_nxt[7:0] = aux_en_r;
      end else if (idx == `RCI_IDX_MAIN_REQ) begin
        prdata_nxt[7:0] = {1'b0, main_req_r};               // selector is write-only
      end else begin
        prdata_nxt[7:0] = aux_req_r;
      end
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs, all straight from flops
  // ------------------------------------------------------------
  assign PRDATA            = prdata_r;
  assign PREADY            = pready_r;
  assign PSLVERR           = slverr_r;
  assign CMD_CODE          = cmd_r;
  assign CMD_START         = start_r;
  assign RECEIVER_SHUTDOWN = rx_off_r;
  assign SOFT_SLEEP        = sleep_r;
  assign IRQ_O             = irq_o_r;
  assign IRQ_OE            = irq_oe_r;
  assign INT_O             = int_r;

endmodule
`default_nettype wire

// File: design/rci_map.svh
// register indices, field positions and reset values of the command/irq register group
`ifndef RCI_MAP_SVH
`define RCI_MAP_SVH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define RCI_IDX_RSVD      6'h00
`define RCI_IDX_CMD       6'h01
`define RCI_IDX_MAIN_EN   6'h02
`define RCI_IDX_AUX_EN    6'h03
`define RCI_IDX_MAIN_REQ  6'h04
`define RCI_IDX_AUX_REQ   6'h05

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RCI_RST_RSVD      8'h00
`define RCI_RST_CMD       8'h20
`define RCI_RST_MAIN_EN   8'h80
`define RCI_RST_AUX_EN    8'h00
`define RCI_RST_MAIN_REQ  8'h14
`define RCI_RST_AUX_REQ   8'h00

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RCI_CMD_RX_OFF    5
`define RCI_CMD_SLEEP     4
`define RCI_EN_POL_INV    7
`define RCI_AUX_DRV_TYPE  7
`define RCI_AUX_EXT_ACT   4
`define RCI_AUX_CHECKSUM  2
`define RCI_REQ_SET_SEL   7
`define RCI_REQ_TX        6
`define RCI_REQ_RX        5
`define RCI_REQ_IDLE      4
`define RCI_REQ_HIGH      3
`define RCI_REQ_LOW       2
`define RCI_REQ_FAULT     1
`define RCI_REQ_COUNT     0
`define RCI_AUX_MASK      8'h14

`endif

// File: design/rci_pkg.sv
// types shared by the command/irq register group
package rci_pkg;

  // power state of the device, one bit flips into sleep and into wake, both bits flip from wake to active
  typedef enum logic [1:0] {
    RCI_ACTIVE = 2'b00,
    RCI_ASLEEP = 2'b01,
    RCI_WAKING = 2'b11
  } rci_pwr_e;

  typedef logic [3:0] rci_cmd_t;
  typedef logic [7:0] rci_reg_t;

endpackage

// File: sim/rci_top_asserts.sv
// concurrent checks on the ports of the command/irq register group
`timescale 1ns/100ps
`default_nettype none
module rci_top_asserts (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PWRITE,
  input wire logic       PREADY,
  input wire logic       PSLVERR,
  input wire logic       CMD_TERMINATED,
  input wire logic       WAKE_READY,
  input wire logic [3:0] CMD_CODE,
  input wire logic       CMD_START,
  input wire logic       RECEIVER_SHUTDOWN,
  input wire logic       SOFT_SLEEP,
  input wire logic       IRQ_O,
  input wire logic       IRQ_OE,
  input wire logic       INT_O
);
  logic wr_done;
  // a host write lands only at the edge that samples pready
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // command code, shutdown and sleep outputs move only on a completed host write, on wake ready or on a command termination;
  // command start rises only on a host write and drops one cycle later; interrupt status falls only on a host write
  a_start_pulse: assert property (CMD_START |-> $past(wr_done) ##1 !CMD_START)
    else $error("command start without a host write or longer than one cycle");
  a_shutdown_write: assert property ($changed(RECEIVER_SHUTDOWN) |-> $past(wr_done))
    else $error("receiver shutdown changed without a host write");
  a_sleep_write: assert property ($rose(SOFT_SLEEP) |-> $past(wr_done))
    else $error("soft sleep entered without a host write");
  a_wake_ready: assert property ($fell(SOFT_SLEEP) |-> $past(WAKE_READY))
    else $error("soft sleep left before wake ready");
  a_term_idle: assert property (CMD_TERMINATED && !wr_done |=> CMD_CODE == 4'h0)
    else $error("command field not idle after termination");
  a_status_clear: assert property ($fell(INT_O) |-> $past(wr_done))
    else $error("interrupt status dropped without a host write");
  // pin pair: released pin never drives a level of its own
  a_pin_release: assert property (!IRQ_OE |-> !IRQ_O)
    else $error("irq level driven while output disabled");
  a_reset_float: assert property ($fell(SYS_RST) |-> !IRQ_OE && !IRQ_O)
    else $error("irq pin not released after reset");
  // main scenarios reached
  cover property ($rose(SOFT_SLEEP));
  cover property ($rose(INT_O));
  cover property (PSLVERR && PREADY);
endmodule
bind rci_top rci_top_asserts chk (.*);
`default_nettype wire

// File: sim/rci_host_model.sv
// apb host model that issues one register transfer at a time
`timescale 1ns/100ps
`default_nettype none
module rci_host_model (
  input  wire logic        clk,
  input  wire logic        pready,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata
);
  logic hung = 1'b0;
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // setup, then access held until pready; released lines show the inverse so stale values never match
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    hung = (n >= 64);
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// File: sim/test_reader_command_irq_regs.sv
// self-checking bench of the command/irq register group
`timescale 1ns/100ps
`default_nettype none
`include "rci_map.svh"
module test_reader_command_irq_regs;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, cmd_start, rx_off, sleep, irq_o, irq_oe, int_o;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [8:0]  ev = 9'h000;
  logic        wake = 1'b0;
  logic [3:0]  cmd_code;
  logic [33:0] q[$];
  logic [33:0] e;
  logic [7:0]  r;
  int          failures = 0;
  int          checks = 0;
  int          seed = 31;
  always #2 clk = ~clk;
  rci_host_model host (.clk(clk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  rci_top uut (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TX_LAST_BIT_SENT(ev[6]),
    .RX_DONE_EV(ev[5]), .CMD_TERMINATED(ev[4]), .FIFO_HIGH_EV(ev[3]), .FIFO_LOW_EV(ev[2]), .FAULT_EV(ev[1]),
    .COUNTDOWN_EV(ev[0]), .CHECKSUM_EV(ev[7]), .EXT_SERIAL_INPUT(ev[8]), .WAKE_READY(wake), .CMD_CODE(cmd_code),
    .CMD_START(cmd_start), .RECEIVER_SHUTDOWN(rx_off), .SOFT_SLEEP(sleep), .IRQ_O(irq_o), .IRQ_OE(irq_oe),
    .INT_O(int_o));
  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // note = {compare data, expected error, expected data}
  task automatic xfer(input logic [5:0] idx, input logic w, input logic [7:0] d, input logic [33:0] note);
    q.push_back(note);
    host.xfer({4'h0, idx, 2'b00}, w, {24'h0, d});
    if (host.hung) begin
      failures++;
      summarize();
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, d, 34'h0);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] x, input logic err);
    xfer(idx, 1'b0, 8'h00, {1'b1, err, 24'h0, x});
  endtask
  // x = {irq_oe, irq_o, int_o, sleep, rx_off}, looked at one edge after the cause
  task automatic pins(input logic [4:0] x);
    @(posedge clk);
    #1;
    checks++;
    if ({irq_oe, irq_o, int_o, sleep, rx_off} !== x) begin
      failures++;
      $display("CHECK FAILED at %0t: pins %b expected %b", $time, {irq_oe, irq_o, int_o, sleep, rx_off}, x);
    end
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  // answer monitor: every completed transfer takes the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      checks++;
      if (pslverr !== e[32] || (e[33] && prdata !== e[31:0])) begin
        failures++;
        $display("CHECK FAILED at %0t: addr %h data %h err %b", $time, paddr, prdata, pslverr);
      end
    end
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    pins(5'b00001);
    rd(`RCI_IDX_RSVD, `RCI_RST_RSVD, 1'b0);
    rd(`RCI_IDX_CMD, `RCI_RST_CMD, 1'b0);
    rd(`RCI_IDX_MAIN_EN, `RCI_RST_MAIN_EN, 1'b0);
    rd(`RCI_IDX_AUX_EN, `RCI_RST_AUX_EN, 1'b0);
    rd(`RCI_IDX_MAIN_REQ, `RCI_RST_MAIN_REQ, 1'b0);
    rd(6'h3f, 8'h00, 1'b1);
    q.push_back({2'b01, 32'h0});
    host.xfer(12'h104, 1'b1, 32'h0000_0010);
    rd(`RCI_IDX_CMD, `RCI_RST_CMD, 1'b0);
    wr(`RCI_IDX_RSVD, 8'hff);
    rd(`RCI_IDX_RSVD, 8'h00, 1'b0);
    r = 8'($random(seed));
    wr(`RCI_IDX_MAIN_EN, r);
    rd(`RCI_IDX_MAIN_EN, r, 1'b0);
    wr(`RCI_IDX_AUX_EN, 8'hff);
    rd(`RCI_IDX_AUX_EN, 8'h94, 1'b0);
    wr(`RCI_IDX_MAIN_EN, 8'h00);
    wr(`RCI_IDX_MAIN_REQ, 8'h7f);
    rd(`RCI_IDX_MAIN_REQ, 8'h00, 1'b0);
    pulse(1);
    pins(5'b10001);
    rd(`RCI_IDX_MAIN_REQ, 8'h02, 1'b0);
    wr(`RCI_IDX_MAIN_EN, 8'h02);
    pins(5'b11101);
    wr(`RCI_IDX_MAIN_EN, 8'h82);
    pins(5'b10101);
    wr(`RCI_IDX_AUX_EN, 8'h14);
    pins(5'b10101);
    wr(`RCI_IDX_MAIN_EN, 8'h02);
    pins(5'b00101);
    wr(`RCI_IDX_MAIN_REQ, 8'h02);
    pins(5'b10001);
    wr(`RCI_IDX_MAIN_EN, 8'h7f);
    for (int i = 0; i < 7; i++) begin
      if (i != 4) begin
        pulse(i);
        pins(5'b00101);
        rd(`RCI_IDX_MAIN_REQ, 8'(1 << i), 1'b0);
        wr(`RCI_IDX_MAIN_REQ, 8'(1 << i));
      end
    end
    wr(`RCI_IDX_MAIN_REQ, 8'h81);
    rd(`RCI_IDX_MAIN_REQ, 8'h01, 1'b0);
    wr(`RCI_IDX_MAIN_REQ, 8'h01);
    pulse(8);
    pulse(7);
    pins(5'b00101);
    rd(`RCI_IDX_AUX_REQ, 8'h14, 1'b0);
    wr(`RCI_IDX_AUX_REQ, 8'h14);
    wr(`RCI_IDX_CMD, 8'h03);
    #1;
    checks++;
    if (cmd_start !== 1'b1 || cmd_code !== 4'h3) begin
      failures++;
      $display("CHECK FAILED at %0t: launch code %h start %b", $time, cmd_code, cmd_start);
    end
    pins(5'b10000);
    rd(`RCI_IDX_CMD, 8'h03, 1'b0);
    pulse(4);
    rd(`RCI_IDX_CMD, 8'h00, 1'b0);
    rd(`RCI_IDX_MAIN_REQ, 8'h10, 1'b0);
    wr(`RCI_IDX_MAIN_REQ, 8'h10);
    wr(`RCI_IDX_CMD, 8'h03);
    wr(`RCI_IDX_CMD, 8'h00);
    rd(`RCI_IDX_MAIN_REQ, 8'h00, 1'b0);
    wr(`RCI_IDX_CMD, 8'h10);
    pins(5'b10010);
    rd(`RCI_IDX_CMD, 8'h10, 1'b0);
    wr(`RCI_IDX_CMD, 8'h00);
    rd(`RCI_IDX_CMD, 8'h10, 1'b0);
    wake <= 1'b1;
    rd(`RCI_IDX_CMD, 8'h00, 1'b0);
    wr(`RCI_IDX_CMD, 8'h0f);
    wr(`RCI_IDX_CMD, 8'h1f);
    pins(5'b10000);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`RCI_IDX_CMD, `RCI_RST_CMD, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
